// ---- gen_source.sv ----
// Partner model: generator pins and event sources feeding the mixer
`timescale 1ns/1ps
module gen_source (
  input  wire logic       clk_i,      // System clock
  input  wire logic [7:0] hi_cmd_i,   // Wanted high pin levels
  input  wire logic [7:0] lo_cmd_i,   // Wanted low pin levels
  input  wire logic [3:0] ev_code_i,  // Event source to excite
  input  wire logic [7:0] ev_val_i,   // Per-generator level for it
  output logic      [7:0] hi_o,       // High pin levels
  output logic      [7:0] lo_o,       // Low pin levels
  output logic      [7:0] src_o [16]  // Event sources by code
);
  // Reserved codes light every source so a leak through them shows
  wire resv = (ev_code_i > 4'h9) && (ev_code_i != 4'hf);
  always_ff @(posedge clk_i) begin
    hi_o <= hi_cmd_i;
    lo_o <= lo_cmd_i;
    for (int c = 0; c < 16; c++) begin
      src_o[c] <= (resv || ev_code_i == 4'(c)) ? ev_val_i : 8'h00;
    end
  end
endmodule

// ---- pwm_mix.sv ----
// PWM combinational logic units, event routers, random register, generator control
//
// The implementer's own choices: the APB register port and the register addresses.
`timescale 1ns/1ps
//
// Notes on behaviour
// - 4-bit input code n picks generator n/2+1, high if even, low if odd.
// - Each logic input inverts its selected signal when its invert bit is 1.
// - Function 00 OR, 01 AND, 10 XOR; 11 reserved.
// - Destination 001..111 routes result to generator 2..8 pins; 000 disables.
// - Units A, C, E drive high pins; B, D, F drive low pins.
// - Inputs from absent generators read as constant zero.
// - Event pin driven only while pin enable is 1, else internal only.
// - Event active-low bit set makes the event signal active low.
// - Unless stretch disabled, event lasts at least eight peripheral clocks.
// - Sync bit syncs to system clock; with stretch off, pulse is two clocks.
// - 4-bit event code selects trigger, output, fault inputs, ADC, error.
// - Steering and half-cycle events are taken from generator domain signals.
// - Event generator output is taken before output mode and override logic.
// - 3-bit source picks generator 1..8; absent generator gives no event.
// - Random register reads 15 bits; top bit reads zero.
// - Generator runs only while its enable bit is 1.
// - Trigger count field plus one gives PWM cycles per trigger.
// - High-resolution enable selects high-resolution mode, needing 500 MHz clock.
// - Clock select 00 none, 01 master, 10 divided, 11 frequency scaled.
// - Frequency-scaled clock makes the time base scale duty and period.
// - 3-bit mode field selects PWM mode; 011 reserved.
//
module pwm_mix
  import pwm_mix_pkg::*;
#(
  parameter logic [NGEN-1:0] GEN_PRESENT = 8'hff
) (
  input  wire logic              CLK_I,                  // 20 MHz clock
  input  wire logic              RST_I,                  // Sync reset, high
  input  wire logic              PSEL,                   // APB select
  input  wire logic              PENABLE,                // APB enable
  input  wire logic              PWRITE,                 // APB direction
  input  wire logic [7:0]        PADDR,                  // APB byte address
  input  wire logic [31:0]       PWDATA,                 // APB write data
  input  wire logic [3:0]        PSTRB,                  // APB byte strobes
  output logic      [31:0]       PRDATA,                 // APB read data
  output logic                   PREADY,                 // APB ready
  output logic                   PSLVERR,                // APB error
  input  wire logic [NGEN-1:0]   GENERATOR_HIGH_PIN_I,   // Generator high outputs
  input  wire logic [NGEN-1:0]   GENERATOR_LOW_PIN_I,    // Generator low outputs
  input  wire logic [NGEN-1:0]   GEN_RAW_OUT_I,          // Output before mode logic
  input  wire logic [NGEN-1:0]   GENERATOR_TRIGGER_CHOICE_I, // Selected triggers
  input  wire logic [NGEN-1:0]   PCI_SYNC_I,             // Sync active
  input  wire logic [NGEN-1:0]   PCI_FEED_FWD_I,         // Feed-forward active
  input  wire logic [NGEN-1:0]   PCI_CUR_LIMIT_I,        // Current limit active
  input  wire logic [NGEN-1:0]   PCI_FAULT_I,            // Fault active
  input  wire logic [NGEN-1:0]   CENTER_HALF_CYCLE_I,    // Half-cycle indicator
  input  wire logic [NGEN-1:0]   PUSH_PULL_STEERING_I,   // Steering signal
  input  wire logic [NGEN-1:0]   ADC_TRIG1_I,            // ADC trigger 1
  input  wire logic [NGEN-1:0]   ADC_TRIG2_I,            // ADC trigger 2
  input  wire logic [NGEN-1:0]   HIRES_ERROR_I,          // High-res error
  output logic      [NGEN-1:0]   GENERATOR_HIGH_PIN_O,   // High pins after mixing
  output logic      [NGEN-1:0]   GENERATOR_LOW_PIN_O,    // Low pins after mixing
  output logic      [NUNIT-1:0]  EVENT_INTERNAL_O,       // Internal event levels
  output logic      [NUNIT-1:0]  EVENT_OUTPUT_PIN_O,     // Event pin values
  output logic      [NUNIT-1:0]  EVENT_OUTPUT_PIN_OE_O,  // Event pin enables
  output logic      [NGEN-1:0]   GEN_ENABLE_O,           // Generator enables
  output logic      [3*NGEN-1:0] TRIGGER_CYCLE_COUNT_O,  // Trigger counts
  output logic      [NGEN-1:0]   HIGH_RESOLUTION_ENABLE_O, // High-res enables
  output logic      [2*NGEN-1:0] GENERATOR_CLOCK_SELECT_O, // Clock selects
  output logic      [3*NGEN-1:0] PWM_MODE_SELECT_O       // Mode selects
);

  // **********
  // Input synchronisers
  // **********
  // Generators run on foreign clocks, so every source takes two flops
  localparam int SW = NSRC * NGEN;

  logic [SW-1:0] meta_q;
  logic [SW-1:0] sync_q;
  logic [SW-1:0] raw_in;

  assign raw_in = {HIRES_ERROR_I, ADC_TRIG2_I, ADC_TRIG1_I,
                   PUSH_PULL_STEERING_I, CENTER_HALF_CYCLE_I,
                   PCI_FAULT_I, PCI_CUR_LIMIT_I, PCI_FEED_FWD_I,
                   PCI_SYNC_I, GEN_RAW_OUT_I,
                   GENERATOR_TRIGGER_CHOICE_I,
                   GENERATOR_LOW_PIN_I, GENERATOR_HIGH_PIN_I};

  always_ff @(posedge CLK_I) begin
    meta_q <= raw_in;
    sync_q <= meta_q;
  end

  logic [NGEN-1:0] s_high;
  logic [NGEN-1:0] s_low;
  logic [NGEN-1:0] s_trig;
  logic [NGEN-1:0] s_raw;
  logic [NGEN-1:0] s_psync;
  logic [NGEN-1:0] s_ff;
  logic [NGEN-1:0] s_cl;
  logic [NGEN-1:0] s_fault;
  logic [NGEN-1:0] s_half;
  logic [NGEN-1:0] s_push_pull_steering;
  logic [NGEN-1:0] s_adc1;
  logic [NGEN-1:0] s_adc2;
  logic [NGEN-1:0] s_hrerr;

  // Absent generators contribute constant zero
  assign {s_hrerr, s_adc2, s_adc1, s_push_pull_steering, s_half, s_fault, s_cl,
          s_ff, s_psync, s_raw, s_trig, s_low, s_high} =
         sync_q & {NSRC{GEN_PRESENT}};

  // **********
  // Register file
  // **********
  logic [15:0] logic_q [NUNIT];
  logic [15:0] event_q [NUNIT];
  logic [15:0] gctl_q  [NGEN];
  logic [14:0] rand_q;

  logic        setup;
  logic        wr_en;
  logic [15:0] wmask;
  logic [7:0]  a_idx;

  assign setup = PSEL & ~PENABLE;
  assign wr_en = PSEL & PENABLE & PREADY & PWRITE;
  assign wmask = {{8{PSTRB[1]}}, {8{PSTRB[0]}}};
  assign a_idx = {2'h0, PADDR[7:2]};

  // Merge of a write into a register under strobes and writable mask
  function automatic logic [15:0] merge(input logic [15:0] old,
                                        input logic [15:0] msk);
    merge = (old & ~(wmask & msk)) | (PWDATA[15:0] & wmask & msk);
  endfunction

  // Hit flag: address is an aligned word inside a group of n registers
  function automatic logic hit(input logic [7:0] base, input int n);
    logic [7:0] rel;
    rel = PADDR - base;
    hit = (PADDR >= base) && (rel[1:0] == 2'h0) &&
          ({2'h0, rel[7:2]} < 8'(n));
  endfunction

  logic [7:0] log_w;
  logic [7:0] evt_w;
  logic [7:0] gct_w;

  assign log_w = a_idx - {2'h0, OFS_LOGIC[7:2]};
  assign evt_w = a_idx - {2'h0, OFS_EVENT[7:2]};
  assign gct_w = a_idx - {2'h0, OFS_GCTL[7:2]};

  logic hit_log;
  logic hit_evt;
  logic hit_gct;
  logic hit_rnd;
  logic hit_any;

  assign hit_log = hit(OFS_LOGIC, NUNIT);
  assign hit_evt = hit(OFS_EVENT, NUNIT);
  assign hit_gct = hit(OFS_GCTL, NGEN);
  assign hit_rnd = (PADDR == OFS_RAND);
  assign hit_any = hit_log | hit_evt | hit_gct | hit_rnd;

  logic [15:0] rd_mux;

  assign rd_mux = hit_log ? logic_q[log_w[2:0]] & LOGIC_MASK :
                  hit_evt ? event_q[evt_w[2:0]] & EVENT_MASK :
                  hit_gct ? gctl_q[gct_w[2:0]] & GCTL_MASK :
                  hit_rnd ? {1'b0, rand_q} :
                  REG_RESET;

  // No wait state; ready and read data leave flops loaded in setup
  always_ff @(posedge CLK_I) begin
    if (RST_I) begin
      PREADY  <= 1'b0;
      PSLVERR <= 1'b0;
      PRDATA  <= 32'h0000_0000;
    end else begin
      PREADY  <= setup;
      PSLVERR <= setup & ~hit_any;
      PRDATA  <= (setup & ~PWRITE) ? {16'h0000, rd_mux} : 32'h0000_0000;
    end
  end

  genvar g;
  generate
    for (g = 0; g < NUNIT; g++) begin : g_regs
      always_ff @(posedge CLK_I) begin
        if (RST_I) begin
          logic_q[g] <= REG_RESET;
          event_q[g] <= REG_RESET;
        end else begin
          if (wr_en && hit_log && log_w == 8'(g))
            logic_q[g] <= merge(logic_q[g], LOGIC_MASK);
          if (wr_en && hit_evt && evt_w == 8'(g))
            event_q[g] <= merge(event_q[g], EVENT_MASK);
        end
      end
    end
    for (g = 0; g < NGEN; g++) begin : g_gctl
      always_ff @(posedge CLK_I) begin
        if (RST_I)
          gctl_q[g] <= REG_RESET;
        else if (wr_en && hit_gct && gct_w == 8'(g))
          gctl_q[g] <= merge(gctl_q[g], GCTL_MASK);
      end
    end
  endgenerate

  // **********
  // Pseudorandom register
  // **********
  // XNOR feedback keeps the all-zero reset value alive
  logic [15:0] rand_wr;
  logic        rand_fb;

  assign rand_wr = merge({1'b0, rand_q}, RAND_MASK);
  assign rand_fb = ~(rand_q[14] ^ rand_q[13]);

  always_ff @(posedge CLK_I) begin
    if (RST_I)
      rand_q <= REG_RESET[14:0];
    else if (wr_en && hit_rnd)
      rand_q <= rand_wr[14:0];
    else if (rand_q == RAND_ONES)
      rand_q <= REG_RESET[14:0]; // Lock-up state of XNOR form
    else
      rand_q <= {rand_q[13:0], rand_fb};
  end

  // **********
  // Combinational logic units
  // **********
  logic [NUNIT-1:0] unit_out;

  generate
    for (g = 0; g < NUNIT; g++) begin : g_unit
      logic [3:0] c1;
      logic [3:0] c2;
      logic       a;
      logic       b;
      logic [1:0] fn;

      assign c1 = logic_q[g][L_S1 +: 4];
      assign c2 = logic_q[g][L_S2 +: 4];
      // Even code high side, odd code low side of generator n/2+1
      assign a = (c1[0] ? s_low[c1[3:1]] : s_high[c1[3:1]]) ^
                 logic_q[g][L_INV1];
      assign b = (c2[0] ? s_low[c2[3:1]] : s_high[c2[3:1]]) ^
                 logic_q[g][L_INV2];
      assign fn = logic_q[g][L_FN +: 2];
      // Reserved function drives low
      assign unit_out[g] = (fn == FN_OR)  ? (a | b) :
                           (fn == FN_AND) ? (a & b) :
                           (fn == FN_XOR) ? (a ^ b) : 1'b0;
    end
  endgenerate

  // Later units win when two target the same pin
  logic [NGEN-1:0] high_mix;
  logic [NGEN-1:0] low_mix;

  always_comb begin
    high_mix = s_high;
    low_mix  = s_low;
    for (int u = 0; u < NUNIT; u++) begin
      if (logic_q[u][L_DST +: 3] != DST_NONE) begin
        if (u % 2 == 0)
          high_mix[logic_q[u][L_DST +: 3]] = unit_out[u];
        else
          low_mix[logic_q[u][L_DST +: 3]] = unit_out[u];
      end
    end
  end

  always_ff @(posedge CLK_I) begin
    if (RST_I) begin
      GENERATOR_HIGH_PIN_O <= '0;
      GENERATOR_LOW_PIN_O  <= '0;
    end else begin
      GENERATOR_HIGH_PIN_O <= high_mix;
      GENERATOR_LOW_PIN_O  <= low_mix;
    end
  end

  // **********
  // Event routers
  // **********
  // Source selection per code and generator
  function automatic logic pick(input logic [3:0] code, input logic [2:0] n);
    unique case (code)
      EV_TRIG:  pick = s_trig[n];
      EV_RAW:   pick = s_raw[n];
      EV_PSYNC: pick = s_psync[n];
      EV_FF:    pick = s_ff[n];
      EV_CL:    pick = s_cl[n];
      EV_FAULT: pick = s_fault[n];
      EV_HALF:  pick = s_half[n];
      EV_PUSH_PULL_STEERING: pick = s_push_pull_steering[n];
      EV_ADC1:  pick = s_adc1[n];
      EV_ADC2:  pick = s_adc2[n];
      EV_HRERR: pick = s_hrerr[n];
      default:  pick = 1'b0;       // Reserved codes
    endcase
  endfunction

  generate
    for (g = 0; g < NUNIT; g++) begin : g_evt
      logic [2:0] gen;
      logic       sel;
      logic       rise;
      logic       strd;
      logic       sync;
      logic       act;
      logic       prev_q;
      logic [2:0] cnt_q;
      logic [2:0] cnt_d;

      assign gen  = event_q[g][E_GEN +: 3];
      assign sel  = GEN_PRESENT[gen] &
                    pick(event_q[g][E_SEL +: 4], gen);
      assign rise = sel & ~prev_q;
      assign strd = event_q[g][E_STRD];
      assign sync = event_q[g][E_SYNC];

      assign cnt_d = (rise & ~strd)        ? STRETCH_LOAD :
                     (rise & strd & sync)  ? SYNC_LOAD :
                     (cnt_q != CNT_ZERO)   ? cnt_q - 3'h1 : CNT_ZERO;

      // Input is already on the system clock, so unsynced mode passes the level
      assign act = ~strd        ? (sel | cnt_q != CNT_ZERO) :
                   sync         ? (rise | cnt_q != CNT_ZERO) :
                   sel;

      always_ff @(posedge CLK_I) begin
        if (RST_I) begin
          prev_q                   <= 1'b0;
          cnt_q                    <= CNT_ZERO;
          EVENT_INTERNAL_O[g]      <= 1'b0;
          EVENT_OUTPUT_PIN_O[g]    <= 1'b0;
          EVENT_OUTPUT_PIN_OE_O[g] <= 1'b0;
        end else begin
          prev_q                   <= sel;
          cnt_q                    <= cnt_d;
          EVENT_INTERNAL_O[g]      <= act ^ event_q[g][E_POL];
          EVENT_OUTPUT_PIN_O[g]    <= (act ^ event_q[g][E_POL]) &
                                      event_q[g][E_OEN];
          EVENT_OUTPUT_PIN_OE_O[g] <= event_q[g][E_OEN];
        end
      end
    end
  endgenerate

  // **********
  // Generator control low word
  // **********
  // Fields leave the block to the generator time bases
  generate
    for (g = 0; g < NGEN; g++) begin : g_ctl
      always_ff @(posedge CLK_I) begin
        if (RST_I) begin
          GEN_ENABLE_O[g]               <= 1'b0;
          TRIGGER_CYCLE_COUNT_O[3*g +: 3] <= 3'h0;
          HIGH_RESOLUTION_ENABLE_O[g]   <= 1'b0;
          GENERATOR_CLOCK_SELECT_O[2*g +: 2] <= 2'h0;
          PWM_MODE_SELECT_O[3*g +: 3]   <= 3'h0;
        end else begin
          GEN_ENABLE_O[g]               <= gctl_q[g][G_ON];
          TRIGGER_CYCLE_COUNT_O[3*g +: 3] <= gctl_q[g][G_TRG +: 3];
          HIGH_RESOLUTION_ENABLE_O[g]   <= gctl_q[g][G_HR];
          GENERATOR_CLOCK_SELECT_O[2*g +: 2] <= gctl_q[g][G_CLK +: 2];
          PWM_MODE_SELECT_O[3*g +: 3]   <= gctl_q[g][G_MOD +: 3];
        end
      end
    end
  endgenerate

endmodule

// ---- pwm_mix_pkg.sv ----
// Constants for the PWM logic, event and generator-control block
package pwm_mix_pkg;
  localparam int NGEN = 8;
  localparam int NUNIT = 6;
  localparam int NSRC = 13;

  // Register byte offsets
  localparam logic [7:0] OFS_LOGIC = 8'h00;
  localparam logic [7:0] OFS_EVENT = 8'h20;
  localparam logic [7:0] OFS_RAND = 8'h40;
  localparam logic [7:0] OFS_GCTL = 8'h60;
  localparam logic [7:0] OFS_STEP = 8'h04;

  // Writable bit masks and reset values
  localparam logic [15:0] LOGIC_MASK = 16'hfff7;
  localparam logic [15:0] EVENT_MASK = 16'hf0f7;
  localparam logic [15:0] RAND_MASK = 16'h7fff;
  localparam logic [15:0] GCTL_MASK = 16'h879f;
  localparam logic [15:0] REG_RESET = 16'h0000;

  // Logic-unit field positions
  localparam int L_S1 = 12;
  localparam int L_S2 = 8;
  localparam int L_INV1 = 7;
  localparam int L_INV2 = 6;
  localparam int L_FN = 4;
  localparam int L_DST = 0;

  // Event field positions
  localparam int E_OEN = 15;
  localparam int E_POL = 14;
  localparam int E_STRD = 13;
  localparam int E_SYNC = 12;
  localparam int E_SEL = 4;
  localparam int E_GEN = 0;

  // Generator control low field positions
  localparam int G_ON = 15;
  localparam int G_TRG = 8;
  localparam int G_HR = 7;
  localparam int G_CLK = 3;
  localparam int G_MOD = 0;

  localparam logic [1:0] FN_OR = 2'h0;
  localparam logic [1:0] FN_AND = 2'h1;
  localparam logic [1:0] FN_XOR = 2'h2;
  localparam logic [2:0] DST_NONE = 3'h0;

  // Event source codes
  localparam logic [3:0] EV_TRIG = 4'h0;
  localparam logic [3:0] EV_RAW = 4'h1;
  localparam logic [3:0] EV_PSYNC = 4'h2;
  localparam logic [3:0] EV_FF = 4'h3;
  localparam logic [3:0] EV_CL = 4'h4;
  localparam logic [3:0] EV_FAULT = 4'h5;
  localparam logic [3:0] EV_HALF = 4'h6;
  localparam logic [3:0] EV_PUSH_PULL_STEERING = 4'h7;
  localparam logic [3:0] EV_ADC1 = 4'h8;
  localparam logic [3:0] EV_ADC2 = 4'h9;
  localparam logic [3:0] EV_HRERR = 4'hf;

  // Stretch length and two-clock sync pulse
  localparam logic [2:0] STRETCH_LOAD = 3'h7;
  localparam logic [2:0] SYNC_LOAD = 3'h1;
  localparam logic [2:0] CNT_ZERO = 3'h0;
  localparam logic [14:0] RAND_ONES = 15'h7fff;
endpackage

// ---- pwm_mix_props.sv ----
// Checker for bus answers, event shaping and control copies of pwm_mix
`timescale 1ns/1ps
module pwm_mix_props
  import pwm_mix_pkg::*;
(
  input wire logic              CLK_I,                    // Clock
  input wire logic              RST_I,                    // Sync reset
  input wire logic              PSEL,                     // APB select
  input wire logic              PENABLE,                  // APB enable
  input wire logic              PWRITE,                   // APB direction
  input wire logic [7:0]        PADDR,                    // APB address
  input wire logic [31:0]       PWDATA,                   // APB write data
  input wire logic [3:0]        PSTRB,                    // APB strobes
  input wire logic [31:0]       PRDATA,                   // APB read data
  input wire logic              PREADY,                   // APB ready
  input wire logic              PSLVERR,                  // APB error
  input wire logic [NUNIT-1:0]  EVENT_INTERNAL_O,         // Event levels
  input wire logic [NUNIT-1:0]  EVENT_OUTPUT_PIN_O,       // Event pins
  input wire logic [NUNIT-1:0]  EVENT_OUTPUT_PIN_OE_O,    // Event pin enables
  input wire logic [NGEN-1:0]   GEN_ENABLE_O,             // Enables
  input wire logic [3*NGEN-1:0] TRIGGER_CYCLE_COUNT_O,    // Trigger counts
  input wire logic [NGEN-1:0]   HIGH_RESOLUTION_ENABLE_O, // High-res enables
  input wire logic [2*NGEN-1:0] GENERATOR_CLOCK_SELECT_O, // Clock selects
  input wire logic [3*NGEN-1:0] PWM_MODE_SELECT_O         // Mode selects
);
  // **********
  // Helper decode and a shadow of event router A
  // **********
  wire mapped = (PADDR[1:0] == 2'h0) && ((PADDR < 8'h18) || (PADDR >= 8'h20 && PADDR < 8'h38)
                || (PADDR == OFS_RAND) || (PADDR >= 8'h60 && PADDR < 8'h80));
  wire wr_full = PSEL && PENABLE && PREADY && PWRITE && (PSTRB == 4'h3);
  wire [15:0] wd = PWDATA[15:0];
  wire [15:0] gview = {GEN_ENABLE_O[0], 4'h0, TRIGGER_CYCLE_COUNT_O[2:0],
                       HIGH_RESOLUTION_ENABLE_O[0], 2'h0, GENERATOR_CLOCK_SELECT_O[1:0],
                       PWM_MODE_SELECT_O[2:0]};
  logic [15:0] evt_a_q;
  always_ff @(posedge CLK_I) begin
    if (RST_I) evt_a_q <= 16'h0000;
    else if (wr_full && PADDR == OFS_EVENT) evt_a_q <= wd & EVENT_MASK;
  end
  // Only judged while router A is known to be active high
  wire stretch_a = !evt_a_q[E_STRD] && !evt_a_q[E_POL];
  wire pulse2_a = evt_a_q[E_STRD] && evt_a_q[E_SYNC] && !evt_a_q[E_POL];

  default clocking cb @(posedge CLK_I); endclocking
  default disable iff (RST_I);

  a_ready_after_setup: assert property (PSEL && !PENABLE |=> PREADY)
    else $error("ready missing after setup");
  a_ready_one_cycle: assert property (PREADY |=> !PREADY)
    else $error("ready held too long");
  a_err_decode: assert property (PSEL && !PENABLE |=> PSLVERR == !$past(mapped))
    else $error("error flag does not match decode");
  a_err_zero_data: assert property (PSLVERR |-> PREADY && PRDATA == 32'h0)
    else $error("error answer not clean");
  a_rand_top_zero: assert property (PREADY && !PWRITE && PADDR == OFS_RAND |-> PRDATA[31:15] == '0)
    else $error("random read top bits set");
  a_event_pin_gate: assert property (EVENT_OUTPUT_PIN_O == (EVENT_INTERNAL_O & EVENT_OUTPUT_PIN_OE_O))
    else $error("event pin not gated by enable");
  a_gen_ctl_copy: assert property (wr_full && PADDR == OFS_GCTL |-> ##2 gview == ($past(wd, 2) & GCTL_MASK))
    else $error("generator control outputs wrong");
  a_stretch_eight: assert property (stretch_a && $rose(EVENT_INTERNAL_O[0]) |-> EVENT_INTERNAL_O[0] [*8])
    else $error("event pulse shorter than eight");
  a_sync_two_clk: assert property (pulse2_a && $rose(EVENT_INTERNAL_O[0]) |=> EVENT_INTERNAL_O[0] ##1 !EVENT_INTERNAL_O[0])
    else $error("synced pulse not two clocks");
endmodule

// ---- tb.sv ----
// Testbench for pwm_mix: register, mixing, event and control scenarios
`timescale 1ns/1ps
module tb;
  import pwm_mix_pkg::*;
  logic        clk, rst, psel, penable, pwrite, pready, pslverr, e, r, x, y, ex;
  logic [7:0]  paddr, hcmd, lcmd, val, hi_o, lo_o, hi_p, lo_p, eh, el;
  logic [3:0]  pstrb, code;
  logic [31:0] pwdata, prdata, rr, r2;
  logic [15:0] gd;
  logic [5:0]  ev_int, ev_pin, ev_oe;
  logic [7:0]  gen_en, hr_en, src [16];
  logic [23:0] trg_cnt, mode_sel;
  logic [15:0] clk_sel;
  int          fails, checks, cycles, u, g, n;

  gen_source stage (.clk_i(clk), .hi_cmd_i(hcmd), .lo_cmd_i(lcmd), .ev_code_i(code),
                    .ev_val_i(val), .hi_o(hi_p), .lo_o(lo_p), .src_o(src));
  // Generator 8 absent so the tie-to-zero paths are exercised
  pwm_mix #(.GEN_PRESENT(8'h7f)) dut (
    .CLK_I(clk), .RST_I(rst), .PSEL(psel), .PENABLE(penable), .PWRITE(pwrite),
    .PADDR(paddr), .PWDATA(pwdata), .PSTRB(pstrb), .PRDATA(prdata), .PREADY(pready),
    .PSLVERR(pslverr), .GENERATOR_HIGH_PIN_I(hi_p), .GENERATOR_LOW_PIN_I(lo_p),
    .GEN_RAW_OUT_I(src[1]), .GENERATOR_TRIGGER_CHOICE_I(src[0]), .PCI_SYNC_I(src[2]),
    .PCI_FEED_FWD_I(src[3]), .PCI_CUR_LIMIT_I(src[4]), .PCI_FAULT_I(src[5]),
    .CENTER_HALF_CYCLE_I(src[6]), .PUSH_PULL_STEERING_I(src[7]), .ADC_TRIG1_I(src[8]),
    .ADC_TRIG2_I(src[9]), .HIRES_ERROR_I(src[15]), .GENERATOR_HIGH_PIN_O(hi_o),
    .GENERATOR_LOW_PIN_O(lo_o), .EVENT_INTERNAL_O(ev_int), .EVENT_OUTPUT_PIN_O(ev_pin),
    .EVENT_OUTPUT_PIN_OE_O(ev_oe), .GEN_ENABLE_O(gen_en), .TRIGGER_CYCLE_COUNT_O(trg_cnt),
    .HIGH_RESOLUTION_ENABLE_O(hr_en), .GENERATOR_CLOCK_SELECT_O(clk_sel),
    .PWM_MODE_SELECT_O(mode_sel));

  initial begin
    clk = 1'b0;
    forever #25 clk = ~clk;
  end

  // **********
  // Shared tasks
  // **********
  task automatic chk(input logic [31:0] s, input logic [31:0] x_e);
    checks++;
    if (s !== x_e) begin
      fails++;
      $display("Error at %0t: seen %h expected %h", $time, s, x_e);
    end
  endtask
  task automatic results;
    $display("Checks %0d, mismatches %0d", checks, fails);
    if (fails == 0 && checks > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask
  task automatic cyc(input int k);
    repeat (k) @(posedge clk);
  endtask
  // Holds the request until ready
  task automatic apb(input logic w, input logic [7:0] a, input logic [15:0] d,
                     input logic [3:0] s, output logic [31:0] rd, output logic er);
    @(posedge clk);
    psel <= 1'b1; penable <= 1'b0; pwrite <= w; paddr <= a; pwdata <= {16'h0, d}; pstrb <= s;
    @(posedge clk);
    penable <= 1'b1;
    do @(posedge clk);
    while (pready !== 1'b1);
    rd = prdata;
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic wr(input logic [7:0] a, input logic [15:0] d);
    apb(1'b1, a, d, 4'h3, rr, e);
  endtask
  task automatic rdc(input logic [7:0] a, input logic [31:0] d);
    apb(1'b0, a, 16'h0, 4'h3, rr, e);
    chk(rr, d);
  endtask
  // Pulses the event source w clocks and counts high cycles of router k
  task automatic pulse(input int k, input int w, output int cnt);
    cnt = 0;
    val <= 8'h01;
    for (int i = 0; i < 24; i++) begin
      @(posedge clk);
      if (i == w - 1) val <= 8'h00;
      if (ev_int[k] === 1'b1) cnt++;
    end
  endtask

  always @(posedge clk) begin
    cycles++;
    if (cycles == 20000) begin
      fails++;
      results();
    end
  end

  // **********
  // Main sequence
  // **********
  initial begin
    rst = 1'b1; psel = 1'b0; penable = 1'b0; pwrite = 1'b0; paddr = 8'h0; pwdata = 32'h0;
    pstrb = 4'h0; hcmd = 8'h0; lcmd = 8'h0; code = 4'h0; val = 8'h0;
    repeat (2) @(posedge clk);
    rst <= 1'b0;
    for (int i = 0; i < 8; i++) begin
      rdc(OFS_GCTL + 8'(4 * i), 32'h0);
      if (i < 6) rdc(OFS_EVENT + 8'(4 * i), 32'h0);
      if (i < 6) rdc(OFS_LOGIC + 8'(4 * i), 32'h0);
    end
    wr(OFS_LOGIC, 16'hffff);
    rdc(OFS_LOGIC, 32'hfff7);
    wr(OFS_EVENT, 16'hffff);
    rdc(OFS_EVENT, 32'hf0f7);
    wr(OFS_LOGIC, 16'h0);
    wr(OFS_EVENT, 16'h0);
    apb(1'b0, 8'h18, 16'h0, 4'h3, rr, e);
    chk(rr, 32'h0);
    chk(e, 1'b1);
    apb(1'b1, 8'h80, 16'hffff, 4'h3, rr, e);
    chk(e, 1'b1);
    apb(1'b0, OFS_RAND, 16'h0, 4'h3, rr, e);
    apb(1'b0, OFS_RAND, 16'h0, 4'h3, r2, e);
    chk(rr[31:15], 17'h0);
    chk(rr !== r2, 1'b1);
    $display("Test registers done");
    // Every source code of unit A through an AND with itself
    hcmd <= 8'hb2;
    lcmd <= 8'hcd;
    for (int k = 0; k < 16; k++) begin
      wr(OFS_LOGIC, {4'(k), 4'(k), 2'b00, FN_AND, 1'b0, 3'h1});
      cyc(6);
      g = k >> 1;
      eh = 8'hb2;
      eh[1] = (g == 7) ? 1'b0 : (k[0] ? lcmd[g] : hcmd[g]);
      chk(hi_o[6:0], eh[6:0]);
    end
    wr(OFS_LOGIC, 16'h0);
    for (int f = 0; f < 4; f++) begin
      for (int iv = 0; iv < 4; iv++) begin
        u = (f * 4 + iv) % 6;
        wr(OFS_LOGIC + 8'(4 * u), {8'h01, 2'(iv), 2'(f), 1'b0, 3'(u + 1)});
        for (int ab = 0; ab < 4; ab++) begin
          hcmd <= 8'h5a | 8'(ab >> 1);
          lcmd <= 8'h24 | 8'(ab & 1);
          cyc(6);
          x = ab[1] ^ iv[1];
          y = ab[0] ^ iv[0];
          r = (f == 0) ? (x | y) : (f == 1) ? (x & y) : (f == 2) ? (x ^ y) : 1'b0;
          eh = hcmd;
          el = lcmd;
          if (u % 2 == 0) eh[u + 1] = r;
          else el[u + 1] = r;
          chk(hi_o[6:0], eh[6:0]);
          chk(lo_o[6:0], el[6:0]);
        end
        wr(OFS_LOGIC + 8'(4 * u), 16'h0);
        cyc(6);
        chk({hi_o[6:0], lo_o[6:0]}, {hcmd[6:0], lcmd[6:0]});
      end
    end
    $display("Test mixing done");
    hcmd <= 8'h0;
    lcmd <= 8'h0;
    for (int c = 0; c < 16; c++) begin
      u = c % 6;
      g = c % 7;
      wr(OFS_EVENT + 8'(4 * u), 16'ha000 | 16'(c << 4) | 16'(g));
      code <= 4'(c);
      val <= 8'(1 << g);
      cyc(7);
      ex = (c < 10) || (c == 15);
      chk(ev_int[u], ex);
      chk({ev_oe[u], ev_pin[u]}, {1'b1, ex});
      val <= 8'h00;
      cyc(7);
      chk(ev_int[u], 1'b0);
      wr(OFS_EVENT + 8'(4 * u), 16'h0);
    end
    wr(OFS_EVENT + 8'h04, 16'ha017);
    code <= 4'h1;
    val <= 8'h80;
    cyc(7);
    chk(ev_int[1], 1'b0);
    wr(OFS_EVENT + 8'h14, 16'h6010);
    val <= 8'h00;
    cyc(7);
    chk({ev_int[5], ev_oe[5], ev_pin[5]}, 3'b100);
    val <= 8'h01;
    cyc(7);
    chk(ev_int[5], 1'b0);
    val <= 8'h00;
    wr(OFS_EVENT + 8'h14, 16'h0);
    wr(OFS_EVENT, 16'h8010);
    pulse(0, 1, n);
    chk(n >= 8, 1'b1);
    wr(OFS_EVENT, 16'h3010);
    pulse(0, 5, n);
    chk(n, 2);
    $display("Test events done");
    for (int k = 0; k < 8; k++) begin
      gd = {k[0], 4'h0, 3'(k), k[1], 2'h0, 2'(k >> 1), 3'(7 - k)};
      wr(OFS_GCTL + 8'(4 * k), gd);
      cyc(2);
      chk({gen_en[k], hr_en[k]}, {gd[15], gd[7]});
      chk(trg_cnt[3*k +: 3], gd[10:8]);
      chk(clk_sel[2*k +: 2], gd[4:3]);
      chk(mode_sel[3*k +: 3], gd[2:0]);
      rdc(OFS_GCTL + 8'(4 * k), {16'h0, gd});
    end
    wr(OFS_GCTL + 8'h04, 16'h0);
    apb(1'b1, OFS_GCTL + 8'h04, 16'hffff, 4'h1, rr, e);
    rdc(OFS_GCTL + 8'h04, 32'h009f);
    wr(OFS_GCTL + 8'h08, 16'hffff);
    rdc(OFS_GCTL + 8'h08, 32'h879f);
    $display("Test generator control done");
    results();
  end
endmodule

bind pwm_mix pwm_mix_props props (.CLK_I(CLK_I), .RST_I(RST_I), .PSEL(PSEL), .PENABLE(PENABLE),
  .PWRITE(PWRITE), .PADDR(PADDR), .PWDATA(PWDATA), .PSTRB(PSTRB), .PRDATA(PRDATA),
  .PREADY(PREADY), .PSLVERR(PSLVERR), .EVENT_INTERNAL_O(EVENT_INTERNAL_O),
  .EVENT_OUTPUT_PIN_O(EVENT_OUTPUT_PIN_O), .EVENT_OUTPUT_PIN_OE_O(EVENT_OUTPUT_PIN_OE_O),
  .GEN_ENABLE_O(GEN_ENABLE_O), .TRIGGER_CYCLE_COUNT_O(TRIGGER_CYCLE_COUNT_O),
  .HIGH_RESOLUTION_ENABLE_O(HIGH_RESOLUTION_ENABLE_O),
  .GENERATOR_CLOCK_SELECT_O(GENERATOR_CLOCK_SELECT_O), .PWM_MODE_SELECT_O(PWM_MODE_SELECT_O));
